// File: shared/aux_seq_pkg.sv
package aux_seq_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] STEP10_CONFIG_INDEX = 8'h9A;
   localparam logic [7:0] STEP11_CONFIG_INDEX = 8'h9B;
   localparam logic [7:0] SEQ_CONTROL_INDEX   = 8'hA0;
   localparam logic [7:0] SEQ_STATUS_INDEX    = 8'hA1;

   // step configuration field positions
   localparam int STEP_ENABLE_BIT = 15;
   localparam int STEP_GAIN_HI    = 14;
   localparam int STEP_GAIN_LO    = 13;
   localparam int STEP_RSVD_HI    = 12;
   localparam int STEP_RSVD_LO    = 5;
   localparam int STEP_NEG_BIT    = 4;
   localparam int STEP_POS_HI     = 3;
   localparam int STEP_POS_LO     = 0;

   // reset values
   localparam logic [15:0] STEP10_CONFIG_RESET = 16'h000A;
   localparam logic [15:0] STEP11_CONFIG_RESET = 16'h000B;
   localparam logic [15:0] SEQ_CONTROL_RESET   = 16'h0000;

   // writable bits of a step word; reserved bits always read zero
   localparam logic [15:0] STEP_WRITE_MASK = 16'hE01F;

   // control and status bits
   localparam int CONTROL_RUN_BIT  = 0;
   localparam int STATUS_BUSY_BIT  = 0;
   localparam int STATUS_STEP_BIT  = 1;
   localparam int STATUS_AUTO_BIT  = 2;

   // gain codes and the factor each one gives
   localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
   localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
   localparam logic [2:0] GAIN_FACTOR_1 = 3'h1;
   localparam logic [2:0] GAIN_FACTOR_2 = 3'h2;
   localparam logic [2:0] GAIN_FACTOR_4 = 3'h4;

   // positive input codes
   localparam logic [3:0] POS_EXT_INPUT_7  = 4'h7;
   localparam logic [3:0] POS_TEMP_SENSOR  = 4'h8;
   localparam logic [3:0] POS_GROUND_SHORT = 4'h9;
   localparam logic [3:0] POS_TEST_DAC     = 4'hA;
   localparam logic [3:0] POS_ANALOG_SUPPLY_DIV4  = 4'hB;
   localparam logic [3:0] POS_IO_SUPPLY_DIV4      = 4'hC;
   localparam logic [3:0] POS_DIGITAL_SUPPLY_DIV2 = 4'hD;
   localparam logic [3:0] POS_ANALOG_POWER_DIV103 = 4'hE;
   localparam logic [3:0] POS_DIGITAL_POWER_DIV103 = 4'hF;

   // negative input source applied to the converter
   typedef enum logic [1:0] {
      NEG_ANALOG_GROUND = 2'h0,
      NEG_EXT_INPUT_7   = 2'h1,
      NEG_AUTOMATIC     = 2'h2
   } neg_source_t;

   // one step configuration word
   typedef struct packed {
      logic       enable;
      logic [1:0] gain_select;
      logic [7:0] reserved;
      logic       neg_input_select;
      logic [3:0] pos_input_select;
   } step_cfg_t;

   // selection that the sequencer drives into the converter front end
   typedef struct packed {
      logic [2:0]  gain_factor;
      logic [3:0]  pos_input;
      logic        pos_internal;
      neg_source_t neg_source;
   } mux_sel_t;

   // sequencer states, gray along idle -> step10 -> step11
   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'h0,
      SEQ_STEP10 = 2'h1,
      SEQ_STEP11 = 2'h3
   } seq_state_t;

endpackage

// File: verilog/aux_step_decode.sv
// turns a stored step word into the converter front-end selection
module aux_step_decode (
   // stored step word
   input  wire aux_seq_pkg::step_cfg_t cfg,
   // decoded selection
   output aux_seq_pkg::mux_sel_t       sel
);

   // gain, positive and negative input decode
   always_comb begin
      unique case (cfg.gain_select)
         aux_seq_pkg::GAIN_CODE_X1: sel.gain_factor = aux_seq_pkg::GAIN_FACTOR_1;
         aux_seq_pkg::GAIN_CODE_X2: sel.gain_factor = aux_seq_pkg::GAIN_FACTOR_2;
         default: sel.gain_factor = aux_seq_pkg::GAIN_FACTOR_4;
      endcase
      sel.pos_input    = cfg.pos_input_select;
      // codes above the eighth external input pick internal sources
      sel.pos_internal = cfg.pos_input_select > aux_seq_pkg::POS_EXT_INPUT_7;
      if (sel.pos_internal) begin
         sel.neg_source = aux_seq_pkg::NEG_AUTOMATIC;
      end else if (cfg.neg_input_select) begin
         sel.neg_source = aux_seq_pkg::NEG_EXT_INPUT_7;
      end else begin
         sel.neg_source = aux_seq_pkg::NEG_ANALOG_GROUND;
      end
   end

endmodule

// File: verilog/aux_seq_steps.sv
// How it works
// - bit 15 puts step ten in sequence
// - gain code 00 x1, 01 x2, else x4
// - bits 12:5 read-only, always zero
// - bit 4 picks ground or eighth input
// - codes 0-7 pick external inputs 0-7
// - codes 8-15 pick internal sources
// - internal source forces automatic negative input
// - step ten at 9Ah, resets 000Ah
// - step eleven at 9Bh, resets 000Bh
// - step eleven uses same field layout
module aux_seq_steps (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  nrst,
   // wishbone classic slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [31:0]           wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // converter handshake
   input  wire logic                  conv_done,
   output logic                       conv_request,
   output logic                       conv_step,
   output aux_seq_pkg::mux_sel_t      conv_sel
);

   aux_seq_pkg::step_cfg_t   step10_cfg;
   aux_seq_pkg::step_cfg_t   step11_cfg;
   logic [15:0]              seq_control;
   aux_seq_pkg::seq_state_t  seq_state;
   aux_seq_pkg::seq_state_t  next_seq_state;
   aux_seq_pkg::mux_sel_t    step10_sel;
   aux_seq_pkg::mux_sel_t    step11_sel;
   aux_seq_pkg::mux_sel_t    next_conv_sel;
   logic                     bus_req;
   logic                     bus_write;
   logic [15:0]              read_word;
   logic [15:0]              status_word;
   logic                     seq_run;

   // byte address to word index; upper address bits must be zero
   function automatic logic hit(input logic [31:0] adr,
                                input logic [7:0] index);
      hit = adr == {22'h000000, index, 2'h0};
   endfunction

   // merge write data into a 16-bit register under the byte enables
   function automatic logic [15:0] merge(input logic [15:0] old_word,
                                         input logic [31:0] data,
                                         input logic [3:0] sel,
                                         input logic [15:0] mask);
      logic [15:0] word;
      word = old_word;
      if (sel[0]) begin
         word[7:0] = data[7:0];
      end
      if (sel[1]) begin
         word[15:8] = data[15:8];
      end
      merge = word & mask;
   endfunction

   // request is taken once, in the cycle before ack rises
   assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_write = bus_req & wb_we_i;
   assign seq_run   = seq_control[aux_seq_pkg::CONTROL_RUN_BIT];

   // one wait-free cycle answer; unmapped addresses are acked too
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // step ten word; reserved bits are masked so they never store
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         step10_cfg <= aux_seq_pkg::STEP10_CONFIG_RESET;
      end else if (bus_write &&
                   hit(wb_adr_i, aux_seq_pkg::STEP10_CONFIG_INDEX)) begin
         step10_cfg <= merge(step10_cfg, wb_dat_i, wb_sel_i,
                             aux_seq_pkg::STEP_WRITE_MASK);
      end
   end

   // step eleven word, same layout as step ten
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         step11_cfg <= aux_seq_pkg::STEP11_CONFIG_RESET;
      end else if (bus_write &&
                   hit(wb_adr_i, aux_seq_pkg::STEP11_CONFIG_INDEX)) begin
         step11_cfg <= merge(step11_cfg, wb_dat_i, wb_sel_i,
                             aux_seq_pkg::STEP_WRITE_MASK);
      end
   end

   // sequencer control: only the run bit is kept
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         seq_control <= aux_seq_pkg::SEQ_CONTROL_RESET;
      end else if (bus_write &&
                   hit(wb_adr_i, aux_seq_pkg::SEQ_CONTROL_INDEX)) begin
         seq_control <= merge(seq_control, wb_dat_i, wb_sel_i,
                              16'h0001);
      end
   end

   // status shows where the sequencer stands
   always_comb begin
      status_word = 16'h0000;
      status_word[aux_seq_pkg::STATUS_BUSY_BIT] =
         seq_state != aux_seq_pkg::SEQ_IDLE;
      status_word[aux_seq_pkg::STATUS_STEP_BIT] =
         seq_state == aux_seq_pkg::SEQ_STEP11;
      status_word[aux_seq_pkg::STATUS_AUTO_BIT] =
         conv_sel.neg_source == aux_seq_pkg::NEG_AUTOMATIC;
   end

   // read multiplexer; anything unmapped reads as zero
   always_comb begin
      read_word = 16'h0000;
      if (hit(wb_adr_i, aux_seq_pkg::STEP10_CONFIG_INDEX)) begin
         read_word = step10_cfg & aux_seq_pkg::STEP_WRITE_MASK;
      end else if (hit(wb_adr_i, aux_seq_pkg::STEP11_CONFIG_INDEX)) begin
         read_word = step11_cfg & aux_seq_pkg::STEP_WRITE_MASK;
      end else if (hit(wb_adr_i, aux_seq_pkg::SEQ_CONTROL_INDEX)) begin
         read_word = seq_control;
      end else if (hit(wb_adr_i, aux_seq_pkg::SEQ_STATUS_INDEX)) begin
         read_word = status_word;
      end
   end

   // read data is captured with the ack of a read and held until the next read
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wb_dat_o <= 32'h00000000;
      end else if (bus_req && !wb_we_i) begin
         wb_dat_o <= {16'h0000, read_word};
      end
   end

   // per-step decode of the stored words
   aux_step_decode u_step10_decode (
      .cfg (step10_cfg),
      .sel (step10_sel)
   );

   aux_step_decode u_step11_decode (
      .cfg (step11_cfg),
      .sel (step11_sel)
   );

   // next step: walk forward, skipping disabled steps, wrap around
   always_comb begin
      next_seq_state = seq_state;
      if (!seq_run) begin
         next_seq_state = aux_seq_pkg::SEQ_IDLE;
      end else begin
         unique case (seq_state)
            aux_seq_pkg::SEQ_IDLE: begin
               if (step10_cfg.enable) begin
                  next_seq_state = aux_seq_pkg::SEQ_STEP10;
               end else if (step11_cfg.enable) begin
                  next_seq_state = aux_seq_pkg::SEQ_STEP11;
               end
            end
            aux_seq_pkg::SEQ_STEP10: begin
               if (conv_done) begin
                  if (step11_cfg.enable) begin
                     next_seq_state = aux_seq_pkg::SEQ_STEP11;
                  end else if (!step10_cfg.enable) begin
                     next_seq_state = aux_seq_pkg::SEQ_IDLE;
                  end
               end
            end
            aux_seq_pkg::SEQ_STEP11: begin
               if (conv_done) begin
                  if (step10_cfg.enable) begin
                     next_seq_state = aux_seq_pkg::SEQ_STEP10;
                  end else if (!step11_cfg.enable) begin
                     next_seq_state = aux_seq_pkg::SEQ_IDLE;
                  end
               end
            end
            default: next_seq_state = aux_seq_pkg::SEQ_IDLE;
         endcase
      end
   end

   // sequencer state
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         seq_state <= aux_seq_pkg::SEQ_IDLE;
      end else begin
         seq_state <= next_seq_state;
      end
   end

   // selection for the step about to run; held while idle so the
   // front end does not glitch between sequences
   // loaded only when a step starts, so a word rewritten mid-step
   // takes effect at the next advance, never under a running step
   always_comb begin
      next_conv_sel = conv_sel;
      if (seq_state == aux_seq_pkg::SEQ_IDLE || conv_done) begin
         if (next_seq_state == aux_seq_pkg::SEQ_STEP10) begin
            next_conv_sel = step10_sel;
         end else if (next_seq_state == aux_seq_pkg::SEQ_STEP11) begin
            next_conv_sel = step11_sel;
         end
      end
   end

   // selection register; it moves on the same edge as the state, so the
   // front end never sees one step's gain with another step's inputs
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         conv_sel <= '0;
      end else begin
         conv_sel <= next_conv_sel;
      end
   end

   // busy level towards the converter
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         conv_request <= 1'b0;
      end else begin
         conv_request <= next_seq_state != aux_seq_pkg::SEQ_IDLE;
      end
   end

   // which step runs; low while idle as well
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         conv_step <= 1'b0;
      end else begin
         conv_step <= next_seq_state == aux_seq_pkg::SEQ_STEP11;
      end
   end

endmodule

// File: verif/aux_seq_steps_monitor.sv
// bus and selection checks, all on the one system clock
module aux_seq_steps_monitor (
   // clock and reset
   input wire logic                   sys_clk,
   input wire logic                   nrst,
   // register bus
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic [31:0]            wb_adr_i,
   input wire logic [31:0]            wb_dat_o,
   input wire logic                   wb_ack_o,
   // converter side
   input wire logic                   conv_done,
   input wire logic                   conv_request,
   input wire logic                   conv_step,
   input wire aux_seq_pkg::mux_sel_t  conv_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // ack is a one-cycle answer to a request taken one edge before
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack missing");
   // both step words sit in one 8-byte slot
   a_rsvd_zero: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i[31:3] == 29'h4D |-> wb_dat_o[12:5] == 8'h00)
      else $error("reserved bits set");
   a_gain_code: assert property (conv_request |->
      conv_sel.gain_factor inside {3'h1, 3'h2, 3'h4})
      else $error("bad gain");
   a_pos_internal: assert property (conv_request |->
      conv_sel.pos_internal == conv_sel.pos_input[3])
      else $error("internal flag");
   a_auto_neg: assert property (conv_request && conv_sel.pos_input[3]
      |-> conv_sel.neg_source == aux_seq_pkg::NEG_AUTOMATIC)
      else $error("negative not automatic");
   a_manual_neg: assert property (conv_request && !conv_sel.pos_input[3]
      |-> conv_sel.neg_source != aux_seq_pkg::NEG_AUTOMATIC)
      else $error("negative automatic");
   // a running step keeps its selection until the converter finishes
   a_step_hold: assert property (conv_request && !conv_done
      |=> $stable(conv_sel) && $stable(conv_step))
      else $error("selection moved");
endmodule

// File: verif/test_aux_seq_steps.sv
module test_aux_seq_steps;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, nrst, cyc, stb, we, done, ack, req, step;
   logic [31:0] adr, dat, dat_o, r;
   logic [3:0] sel, bs;
   logic [15:0] m [2], w, w11;
   aux_seq_pkg::mux_sel_t csel;
   int n_errors, checks, cycles;

   aux_seq_steps aux_seq_steps_inst (.sys_clk(sys_clk), .nrst(nrst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .conv_done(done), .conv_request(req), .conv_step(step),
      .conv_sel(csel));

   // clock at 50 MHz
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // expected selection worked out from the step word
   function automatic aux_seq_pkg::mux_sel_t exp_sel(logic [15:0] v);
      aux_seq_pkg::mux_sel_t s;
      s.gain_factor = v[14:13] == 2'h0 ? 3'h1 : v[14:13] == 2'h1 ? 3'h2 : 3'h4;
      s.pos_input = v[3:0];
      s.pos_internal = v[3];
      s.neg_source = v[3] ? aux_seq_pkg::NEG_AUTOMATIC :
         v[4] ? aux_seq_pkg::NEG_EXT_INPUT_7 : aux_seq_pkg::NEG_ANALOG_GROUND;
      return s;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one classic cycle, held until ack is sampled high
   task automatic xfer(input logic [31:0] a, input logic wr,
                       input logic [15:0] d, input logic [3:0] s);
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= a;
      dat <= {16'h0000, d};
      sel <= s;
      do @(posedge sys_clk); while (ack !== 1'b1);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // one-cycle finish pulse, then look once the next step has landed
   task automatic pulse;
      @(posedge sys_clk) done <= 1'b1;
      @(posedge sys_clk) done <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         test_done;
      end
   end

   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      done = 1'b0;
      nrst = 1'b0;
      adr = 32'h0;
      dat = 32'h0;
      sel = 4'h0;
      void'($urandom(32'h334A));
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      xfer(32'h268, 1'b0, 16'h0, 4'h0);
      chk(r, 32'h0000000A);
      xfer(32'h26C, 1'b0, 16'h0, 4'h0);
      chk(r, 32'h0000000B);
      m[0] = 16'h000A;
      m[1] = 16'h000B;
      // random partial writes, reserved bits must stay zero
      for (int i = 0; i < 24; i++) begin
         w = 16'($urandom);
         bs = 4'($urandom);
         w11 = {{8{bs[1]}}, {8{bs[0]}}} & aux_seq_pkg::STEP_WRITE_MASK;
         m[i%2] = (m[i%2] & ~w11) | (w & w11);
         xfer(i % 2 ? 32'h26C : 32'h268, 1'b1, w, bs);
         xfer(i % 2 ? 32'h26C : 32'h268, 1'b0, 16'h0, 4'h0);
         chk(r, {16'h0000, m[i%2]});
      end
      xfer(32'h300, 1'b1, 16'hFFFF, 4'hF);
      xfer(32'h300, 1'b0, 16'h0, 4'h0);
      chk(r, 32'h0);
      // every input code on both steps, alternating order
      for (int i = 0; i < 16; i++) begin
         w = {1'b1, 2'($urandom), 8'h00, 1'($urandom), 4'(i)};
         w11 = {1'b1, 2'($urandom), 8'h00, 1'($urandom), 4'(15 - i)};
         xfer(32'h268, 1'b1, w, 4'h3);
         xfer(32'h26C, 1'b1, w11, 4'h3);
         xfer(32'h280, 1'b1, 16'h0001, 4'h3);
         repeat (2) @(posedge sys_clk);
         #1;
         chk({req, step}, 32'h2);
         chk(32'(csel), 32'(exp_sel(w)));
         pulse;
         chk({req, step}, 32'h3);
         chk(32'(csel), 32'(exp_sel(w11)));
         pulse;
         chk({req, step}, 32'h2);
         xfer(32'h280, 1'b1, 16'h0000, 4'h3);
      end
      // disabled step ten is skipped, a lone step repeats
      xfer(32'h268, 1'b1, 16'h0003, 4'h3);
      xfer(32'h26C, 1'b1, 16'hC016, 4'h3);
      xfer(32'h280, 1'b1, 16'h0001, 4'h3);
      pulse;
      chk({req, step}, 32'h3);
      chk(32'(csel), 32'(exp_sel(16'hC016)));
      // status while step eleven runs: busy, step eleven, manual negative
      xfer(32'h284, 1'b0, 16'h0, 4'h0);
      chk(r, 32'h00000003);
      // a rewrite under a running step must not move its selection
      xfer(32'h26C, 1'b1, 16'h0006, 4'h3);
      chk(32'(csel), 32'(exp_sel(16'hC016)));
      pulse;
      chk({31'h0, req}, 32'h0);
      // reset with the run bit still set brings both words back to their defaults
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      xfer(32'h268, 1'b0, 16'h0, 4'h0);
      chk(r, 32'h0000000A);
      xfer(32'h26C, 1'b0, 16'h0, 4'h0);
      chk(r, 32'h0000000B);
      test_done;
   end
endmodule

bind aux_seq_steps aux_seq_steps_monitor aux_seq_steps_monitor_inst (
   .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_done(conv_done),
   .conv_request(conv_request), .conv_step(conv_step),
   .conv_sel(conv_sel));
